// ===== shared/aci_cfg.svh
`ifndef ACI_CFG_SVH
`define ACI_CFG_SVH
// Framing bytes
`define ACI_CH_BANG 8'h21
`define ACI_CH_CR 8'h0d
`define ACI_CH_LF 8'h0a
`define ACI_CH_COMMA 8'h2c
`define ACI_CH_EQ 8'h3d
`define ACI_CH_ZERO 8'h30
`define ACI_CH_NINE 8'h39
// Command names, packed right-aligned into the name buffer
`define ACI_NM_TRIGGER 128'("TRIGGER")
`define ACI_NM_RUN 128'("RUN")
`define ACI_NM_SETUP 128'("SETUP")
`define ACI_NM_OFFLINE 128'("OFFLINE")
`define ACI_NM_EXPOSURE 128'h5345544558504f53555245
`define ACI_NM_GAIN 128'h5345544741494e
`define ACI_NM_MATCHQ 128'h4745544d41544348535452
// Answer codes
`define ACI_ERR_OK 7'h00
`define ACI_ERR_NOJOB 7'h01
`define ACI_ERR_INDEX 7'h02
`define ACI_ERR_RANGE 7'h03
`define ACI_ERR_UNKNOWN 7'h64
`define ACI_ERR_FORMAT 7'h65
// Setting limits and sizes
`define ACI_NUM_CAPS 16'h0004
`define ACI_EXP_MIN 16'h0001
`define ACI_EXP_MAX 16'h2710
`define ACI_GAIN_MIN 16'h0000
`define ACI_GAIN_MAX 16'h0064
`define ACI_EXP_RESET 16'h0040
`define ACI_GAIN_RESET 16'h0032
`define ACI_NAME_MAX 5'h10
`endif

// ===== shared/aci_pkg.sv
package aci_pkg;
  // Operating modes
  typedef enum logic [1:0] {MODE_RUN, MODE_SETUP, MODE_OFFLINE} aci_mode_type;
  // Settings of one capture
  typedef struct packed {
    logic [15:0] exposure;
    logic [15:0] gain;
  } aci_capture_type;
  // Stored match text, first character in text[0]
  typedef struct packed {
    logic [3:0] len;
    logic [7:0][7:0] text;
  } aci_match_type;
  // One byte of a byte stream
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } aci_byte_type;
endpackage

// ===== design/aci_interp.sv
`timescale 1ns/1ps
`include "aci_cfg.svh"

// Operation
// - Frames start with exclamation mark 0x21
// - Names compared case-sensitively, upper case only
// - Carriage return 0x0D ends the frame
// - Commas separate name and argument fields
// - Every command answers numeric code, zero success
// - Unknown command answers code 100
// - Echo name, equals, decimal code, CR LF
// - Trigger: code line first, then read result
// - Match query: code, comma, stored match text
// - Fieldbus source: no text, code to fault
// - Trigger starts cycle only in Run/Setup
// - Run mode: job change yes, params no; exposure and gain writes are still accepted here
// - Setup mode: job change no, params yes
// - Offline stops triggers; job change yes, params no; exposure and gain writes are still accepted here
// - Exposure/gain: one-based capture index, value
// - No job loaded answers code 1
// - Missing capture index answers code 2
// - Exposure out of range: code 3, unchanged
// - Gain out of range: code 3, unchanged
// - Fewer than two arguments answers code 101
// - Run, Setup, Offline, trigger answer code 0
module aci_interp (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Command byte stream in
  input wire aci_pkg::aci_byte_type cmd_in,
  output logic cmd_ready_q,
  input wire logic fieldbus_src,
  // Answer byte stream out
  output aci_pkg::aci_byte_type rsp_out_q,
  input wire logic rsp_ready,
  // Read result stream from the decoder
  input wire aci_pkg::aci_byte_type result_in,
  output logic result_ready_q,
  // Job state and settings
  input wire logic job_loaded,
  input wire aci_pkg::aci_match_type match_text,
  output aci_pkg::aci_capture_type [3:0] capture_q,
  output aci_pkg::aci_mode_type mode_q,
  output logic job_change_ok_q,
  output logic param_change_ok_q,
  output logic trigger_q,
  // Fieldbus fault code
  output logic [6:0] fault_code_q,
  output logic fault_stb_q
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    S_HUNT, S_NAME, S_ARGS, S_EXEC, S_BANG, S_ECHO, S_EQ, S_D2,
    S_D1, S_D0, S_COMMA, S_MATCH, S_CR, S_LF, S_FWD
  } aci_state_type;

  aci_state_type state_q; // Parser and answer sequencer state
  aci_state_type state_d;
  logic [127:0] name_q; // Received name, last char in low byte
  logic [4:0] name_len_q; // Characters received
  logic name_bad_q; // Name overflowed the buffer
  logic [1:0] nargs_q; // Commas seen, saturating at three
  logic [15:0] arg1_q; // First decimal field
  logic [15:0] arg2_q; // Second decimal field
  logic fb_q; // Frame came from the fieldbus side
  logic [6:0] code_q; // Answer code of the last command
  logic fwd_q; // Read result must follow the answer
  logic match_q; // Answer carries match text
  logic [4:0] idx_q; // Byte index while echoing
  logic [7:0] out_byte; // Byte the sequencer emits now
  logic tx_free; // Output register can take a byte
  logic rx_take; // Input byte accepted this cycle
  logic res_take; // Result byte accepted this cycle
  logic [6:0] code_rem; // Code below one hundred
  logic [15:0] cap_sel; // Zero-based capture index
  logic is_exp;
  logic is_gain;
  logic is_trig;
  logic [6:0] exec_code;
  logic exec_write;
  logic is_digit;

  assign tx_free = !rsp_out_q.valid || rsp_ready;
  assign rx_take = cmd_in.valid && cmd_ready_q;
  assign res_take = result_in.valid && result_ready_q;
  assign is_digit = cmd_in.data >= `ACI_CH_ZERO
    && cmd_in.data <= `ACI_CH_NINE;
  assign code_rem = (code_q >= 7'd100) ? code_q - 7'd100 : code_q;
  assign cap_sel = arg1_q - 16'h0001;
  assign is_exp = !name_bad_q && name_q == `ACI_NM_EXPOSURE;
  assign is_gain = !name_bad_q && name_q == `ACI_NM_GAIN;
  assign is_trig = !name_bad_q && name_q == `ACI_NM_TRIGGER;

  // ------------------------------------------------------------
  // Command evaluation
  // ------------------------------------------------------------
  // Answer code and write permission of the frame just closed
  always_comb
  begin
    exec_code = `ACI_ERR_OK;
    exec_write = 1'b0;
    if (name_bad_q)
    begin
      exec_code = `ACI_ERR_UNKNOWN;
    end
    else if (is_exp || is_gain)
    begin
      // Format, job, index, range checked in that order
      if (nargs_q < 2'd2)
        exec_code = `ACI_ERR_FORMAT;
      else if (!job_loaded)
        exec_code = `ACI_ERR_NOJOB;
      else if (arg1_q == 16'h0000 || arg1_q > `ACI_NUM_CAPS)
        exec_code = `ACI_ERR_INDEX;
      else if (is_exp && (arg2_q < `ACI_EXP_MIN
               || arg2_q > `ACI_EXP_MAX))
        exec_code = `ACI_ERR_RANGE;
      else if (is_gain && (arg2_q < `ACI_GAIN_MIN
               || arg2_q > `ACI_GAIN_MAX))
        exec_code = `ACI_ERR_RANGE;
      else
        exec_write = 1'b1;
    end
    else if (!(is_trig || name_q == `ACI_NM_RUN
             || name_q == `ACI_NM_SETUP || name_q == `ACI_NM_OFFLINE
             || name_q == `ACI_NM_MATCHQ))
    begin
      // Lower case or misspelt names land here
      exec_code = `ACI_ERR_UNKNOWN;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // Next state and the byte offered to the answer stream
  always_comb
  begin
    state_d = state_q;
    out_byte = 8'h00;
    unique case (state_q)
      S_HUNT:
        if (rx_take && cmd_in.data == `ACI_CH_BANG)
          state_d = S_NAME;
      S_NAME, S_ARGS:
        if (rx_take)
        begin
          if (cmd_in.data == `ACI_CH_BANG)
            state_d = S_NAME;
          else if (cmd_in.data == `ACI_CH_CR)
            state_d = S_EXEC;
          else if (cmd_in.data == `ACI_CH_COMMA)
            state_d = S_ARGS;
        end
      S_EXEC:
        // Fieldbus frames answer through the fault field only
        state_d = fb_q ? S_HUNT : S_BANG;
      S_BANG:
      begin
        out_byte = `ACI_CH_BANG;
        if (tx_free)
          state_d = (name_len_q == 5'h00) ? S_EQ : S_ECHO;
      end
      S_ECHO:
      begin
        out_byte = name_q[8 * (name_len_q - idx_q - 5'h01) +: 8];
        if (tx_free && idx_q + 5'h01 == name_len_q)
          state_d = S_EQ;
      end
      S_EQ:
      begin
        out_byte = `ACI_CH_EQ;
        if (tx_free)
          state_d = (code_q >= 7'd100) ? S_D2
            : (code_q >= 7'd10) ? S_D1 : S_D0;
      end
      S_D2:
      begin
        out_byte = `ACI_CH_ZERO + 8'h01;
        if (tx_free)
          state_d = S_D1;
      end
      S_D1:
      begin
        out_byte = `ACI_CH_ZERO + 8'(code_rem / 7'd10);
        if (tx_free)
          state_d = S_D0;
      end
      S_D0:
      begin
        out_byte = `ACI_CH_ZERO + 8'(code_rem % 7'd10);
        if (tx_free)
          state_d = match_q ? S_COMMA : S_CR;
      end
      S_COMMA:
      begin
        out_byte = `ACI_CH_COMMA;
        if (tx_free)
          state_d = (match_text.len == 4'h0) ? S_CR : S_MATCH;
      end
      S_MATCH:
      begin
        out_byte = match_text.text[idx_q[2:0]];
        if (tx_free && {1'b0, idx_q[3:0]} + 5'h01
            >= {1'b0, match_text.len})
          state_d = S_CR;
      end
      S_CR:
      begin
        out_byte = `ACI_CH_CR;
        if (tx_free)
          state_d = S_LF;
      end
      S_LF:
      begin
        out_byte = `ACI_CH_LF;
        if (tx_free)
          state_d = fwd_q ? S_FWD : S_HUNT;
      end
      S_FWD:
        if (res_take && result_in.last)
          state_d = S_HUNT;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_q <= S_HUNT;
    else
      state_q <= state_d;
  end

  // Input is only taken while hunting for or parsing a frame
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      cmd_ready_q <= 1'b0;
    else
      cmd_ready_q <= state_d == S_HUNT || state_d == S_NAME
        || state_d == S_ARGS;
  end

  // ------------------------------------------------------------
  // Frame capture
  // ------------------------------------------------------------
  // Name buffer, field counter and decimal fields
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      name_q <= 128'h0;
      name_len_q <= 5'h00;
      name_bad_q <= 1'b0;
      nargs_q <= 2'd0;
      arg1_q <= 16'h0000;
      arg2_q <= 16'h0000;
      fb_q <= 1'b0;
    end
    else if (rx_take && cmd_in.data == `ACI_CH_BANG)
    begin
      // Any bang drops what came before it
      name_q <= 128'h0;
      name_len_q <= 5'h00;
      name_bad_q <= 1'b0;
      nargs_q <= 2'd0;
      arg1_q <= 16'h0000;
      arg2_q <= 16'h0000;
    end
    else if (rx_take && cmd_in.data == `ACI_CH_CR)
    begin
      fb_q <= fieldbus_src;
    end
    else if (rx_take && state_q == S_NAME
             && cmd_in.data != `ACI_CH_COMMA)
    begin
      // Long names cannot match anything, so flag them unknown
      if (name_len_q == `ACI_NAME_MAX)
        name_bad_q <= 1'b1;
      else
      begin
        name_q <= {name_q[119:0], cmd_in.data};
        name_len_q <= name_len_q + 5'h01;
      end
    end
    else if (rx_take && cmd_in.data == `ACI_CH_COMMA)
    begin
      if (nargs_q != 2'd3)
        nargs_q <= nargs_q + 2'd1;
    end
    else if (rx_take && state_q == S_ARGS && is_digit)
    begin
      // Only digits count; fields wrap past 65535
      if (nargs_q == 2'd1)
        arg1_q <= 16'(arg1_q * 16'd10 + 16'(cmd_in.data - 8'h30));
      else if (nargs_q == 2'd2)
        arg2_q <= 16'(arg2_q * 16'd10 + 16'(cmd_in.data - 8'h30));
    end
  end

  // ------------------------------------------------------------
  // Execution
  // ------------------------------------------------------------
  // Latch the answer and what must follow it
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      code_q <= `ACI_ERR_OK;
      fwd_q <= 1'b0;
      match_q <= 1'b0;
    end
    else if (state_q == S_EXEC)
    begin
      code_q <= exec_code;
      fwd_q <= is_trig && !name_bad_q && mode_q != aci_pkg::MODE_OFFLINE;
      match_q <= !name_bad_q && name_q == `ACI_NM_MATCHQ;
    end
  end

  // Mode switching; unknown names leave the mode alone
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      mode_q <= aci_pkg::MODE_RUN;
    else if (state_q == S_EXEC && !name_bad_q)
    begin
      if (name_q == `ACI_NM_RUN)
        mode_q <= aci_pkg::MODE_RUN;
      else if (name_q == `ACI_NM_SETUP)
        mode_q <= aci_pkg::MODE_SETUP;
      else if (name_q == `ACI_NM_OFFLINE)
        mode_q <= aci_pkg::MODE_OFFLINE;
    end
  end

  // Permissions follow the mode one cycle later
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      job_change_ok_q <= 1'b1;
      param_change_ok_q <= 1'b0;
    end
    else
    begin
      job_change_ok_q <= mode_q != aci_pkg::MODE_SETUP;
      param_change_ok_q <= mode_q == aci_pkg::MODE_SETUP;
    end
  end

  // One-cycle soft trigger, suppressed while offline
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      trigger_q <= 1'b0;
    else
      trigger_q <= state_q == S_EXEC && is_trig
        && mode_q != aci_pkg::MODE_OFFLINE;
  end

  // Capture settings; a refused write keeps the old value
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        capture_q[i].exposure <= `ACI_EXP_RESET;
        capture_q[i].gain <= `ACI_GAIN_RESET;
      end
    end
    else if (state_q == S_EXEC && exec_write)
    begin
      if (is_exp)
        capture_q[cap_sel[1:0]].exposure <= arg2_q;
      else
        capture_q[cap_sel[1:0]].gain <= arg2_q;
    end
  end

  // Fieldbus fault code and its strobe
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fault_code_q <= 7'h00;
      fault_stb_q <= 1'b0;
    end
    else
    begin
      fault_stb_q <= state_q == S_EXEC && fb_q;
      if (state_q == S_EXEC && fb_q)
        fault_code_q <= exec_code;
    end
  end

  // ------------------------------------------------------------
  // Answer output
  // ------------------------------------------------------------
  // Echo index, reused for the match text bytes
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      idx_q <= 5'h00;
    else if ((state_q == S_ECHO || state_q == S_MATCH) && tx_free)
      idx_q <= (state_d == state_q) ? idx_q + 5'h01 : 5'h00;
    else if (state_q != S_ECHO && state_q != S_MATCH)
      idx_q <= 5'h00;
  end

  // Output register; result bytes only pass into an empty slot
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      rsp_out_q <= '0;
    else if (state_q == S_FWD)
    begin
      if (res_take)
        rsp_out_q <= result_in;
      else if (rsp_ready)
        rsp_out_q.valid <= 1'b0;
    end
    else if (state_q >= S_BANG && tx_free)
    begin
      rsp_out_q.valid <= 1'b1;
      rsp_out_q.last <= state_q == S_LF;
      rsp_out_q.data <= out_byte;
    end
    else if (rsp_ready)
      rsp_out_q.valid <= 1'b0;
  end

  // Ready for result bytes only when the slot will be empty; never on
  // the edge that loads the line feed, or a result byte would clobber it
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      result_ready_q <= 1'b0;
    else
      result_ready_q <= state_q == S_FWD && state_d == S_FWD && !res_take
        && (!rsp_out_q.valid || rsp_ready);
  end

endmodule // aci_interp

// ===== testbench/aci_checker.sv
`timescale 1ns/1ps
module aci_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Command and answer streams
  input wire aci_pkg::aci_byte_type cmd_in,
  input wire logic cmd_ready_q,
  input wire logic fieldbus_src,
  input wire aci_pkg::aci_byte_type rsp_out_q,
  input wire logic rsp_ready,
  input wire logic result_ready_q,
  // Mode and events
  input wire aci_pkg::aci_mode_type mode_q,
  input wire logic job_change_ok_q,
  input wire logic param_change_ok_q,
  input wire logic trigger_q,
  input wire logic fault_stb_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ----------------------------------------
  // Frame tracking
  // ----------------------------------------
  logic framed_q; // Start byte taken, no end byte yet
  wire logic take_w = cmd_in.valid && cmd_ready_q;
  // Only an end byte inside a frame makes an answer
  wire logic cr_w = take_w && cmd_in.data == 8'h0d && framed_q;
  // Follows the start and end bytes the parser has taken
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst)
      framed_q <= 1'b0;
    else if (take_w && cmd_in.data == 8'h21)
      framed_q <= 1'b1;
    else if (take_w && cmd_in.data == 8'h0d)
      framed_q <= 1'b0;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_head;
    rsp_out_q.valid && rsp_out_q.data == 8'h21;
  endsequence
  sequence s_quiet;
    !rsp_out_q.valid && !cmd_ready_q;
  endsequence
  a_answer_start: assert property (cr_w && !fieldbus_src |=> s_quiet [*2] ##1 s_head)
    else $error("answer did not open with the start byte");
  a_fieldbus_quiet: assert property (cr_w && fieldbus_src |=> s_quiet ##1 (fault_stb_q && !rsp_out_q.valid) ##1 !fault_stb_q)
    else $error("fieldbus frame gave text or no fault pulse");
  a_answer_hold: assert property (rsp_out_q.valid && !rsp_ready |=> $stable(rsp_out_q))
    else $error("answer byte changed before it was taken");
  a_trig_mode: assert property (trigger_q |-> $past(mode_q) != aci_pkg::MODE_OFFLINE)
    else $error("trigger fired while offline");
  a_trig_first: assert property (trigger_q && !fault_stb_q |=> s_head)
    else $error("trigger answer line not started with the pulse");
  a_mode_flags: assert property (param_change_ok_q == ($past(mode_q) == aci_pkg::MODE_SETUP) && job_change_ok_q != param_change_ok_q)
    else $error("change permission flags do not match mode");
  a_result_gate: assert property (result_ready_q |-> !rsp_out_q.valid && !cmd_ready_q)
    else $error("result taken while a byte or command pending");
  a_hunt_drop: assert property (take_w && !framed_q && cmd_in.data != 8'h21 |=> cmd_ready_q)
    else $error("byte outside a frame stopped the parser");
endmodule // aci_checker

bind aci_interp aci_checker i_aci_checker (.clk_sys, .sys_rst, .cmd_in,
  .cmd_ready_q, .fieldbus_src, .rsp_out_q, .rsp_ready, .result_ready_q,
  .mode_q, .job_change_ok_q, .param_change_ok_q, .trigger_q, .fault_stb_q);

// ===== testbench/aci_host_model.sv
`timescale 1ns/1ps
module aci_host_model (
  // Clock
  input wire logic clk_sys,
  // Command stream out
  output aci_pkg::aci_byte_type cmd_in,
  input wire logic cmd_ready_q,
  // Answer stream in
  input wire aci_pkg::aci_byte_type rsp_out_q,
  output logic rsp_ready
);
  logic [7:0] tx_q[$]; // Bytes waiting to go out
  string rx; // Answer bytes collected so far
  int n_last; // Final bytes seen
  logic slow; // Stall the answer stream every other cycle
  initial
  begin
    cmd_in = '0;
    rsp_ready = 1'b1;
    slow = 1'b0;
    rx = "";
    n_last = 0;
  end
  // One whole frame; caller waits for its answer first
  task automatic send(input string s);
    foreach (s[i])
      tx_q.push_back(s[i]); // Start byte, name, commas, digits
    tx_q.push_back(8'h0d); // Frame end
  endtask
  // Holds each byte until taken; idle data toggles so no stale value
  always @(posedge clk_sys)
  begin
    if (cmd_in.valid && cmd_ready_q)
      void'(tx_q.pop_front());
    if (tx_q.size() > 0)
      cmd_in <= {1'b1, 1'b0, tx_q[0]};
    else
      cmd_in <= {1'b0, 1'b0, ~cmd_in.data};
  end
  // Collects answer bytes; slow mode exercises the hold rule
  always @(posedge clk_sys)
  begin
    if (rsp_out_q.valid && rsp_ready)
    begin
      rx = {rx, string'(rsp_out_q.data)};
      n_last += rsp_out_q.last;
    end
    rsp_ready <= slow ? ~rsp_ready : 1'b1;
  end
endmodule // aci_host_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, sys_rst, fieldbus_src, job_loaded;
  logic cmd_ready_q, rsp_ready, result_ready_q, trigger_q, fault_stb_q;
  logic job_change_ok_q, param_change_ok_q;
  aci_pkg::aci_byte_type cmd_in, rsp_out_q, result_in;
  aci_pkg::aci_match_type match_text;
  aci_pkg::aci_capture_type [3:0] capture_q;
  aci_pkg::aci_mode_type mode_q;
  logic [6:0] fault_code_q;
  int num_errors, n_tests, n_trig;
  logic [7:0] res_q[$]; // Decoder result bytes
  // Set and query command names as byte codes
  string nm_exp = string'(88'h5345544558504f53555245);
  string nm_gain = string'(56'h5345544741494e);
  string nm_mq = string'(88'h4745544d41544348535452);
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  aci_interp i_aci_interp (.clk_sys, .sys_rst, .cmd_in, .cmd_ready_q,
    .fieldbus_src, .rsp_out_q, .rsp_ready, .result_in, .result_ready_q,
    .job_loaded, .match_text, .capture_q, .mode_q, .job_change_ok_q,
    .param_change_ok_q, .trigger_q, .fault_code_q, .fault_stb_q);
  aci_host_model i_aci_host_model (.clk_sys, .cmd_in, .cmd_ready_q,
    .rsp_out_q, .rsp_ready);
  initial
  begin
    clk_sys = 1'b0;
    sys_rst = 1'b1;
    {fieldbus_src, job_loaded, match_text, result_in} = '0;
    {num_errors, n_tests, n_trig} = '0;
  end
  always #5 clk_sys = ~clk_sys;
  // Decoder stand-in: holds each byte until taken
  always @(posedge clk_sys)
  begin
    if (result_in.valid && result_ready_q)
      void'(res_q.pop_front());
    if (res_q.size() > 0)
      result_in <= {1'b1, res_q.size() == 1, res_q[0]};
    else
      result_in <= {1'b0, 1'b0, ~result_in.data};
  end
  // Counts read cycles started
  always @(posedge clk_sys)
    if (trigger_q === 1'b1)
      n_trig++;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input string seen, input string exp);
    n_tests++;
    if (seen != exp)
    begin
      num_errors++;
      $display("mismatch %s expected %s seen %s", what, exp, seen);
    end
  endtask
  // Sends one frame, waits for n final bytes, compares the text
  task automatic cmd(input string s, input string exp, input int n = 1);
    int k;
    i_aci_host_model.rx = "";
    i_aci_host_model.n_last = 0;
    i_aci_host_model.send(s);
    k = 0;
    // Bounded answer wait; the slow-mode trigger answer also fits in 400 cycles
    while (i_aci_host_model.n_last < n && k < 400)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 400)
    begin
      num_errors++;
      $display("mismatch %s wait expected answer seen none", s);
      summarize();
    end
    check(s, i_aci_host_model.rx, exp);
  endtask
  // Sends a command built from a name and its fields, checks the code
  task automatic scmd(input string nm, input string f, input string c);
    cmd({"!", nm, f}, {"!", nm, "=", c, "\r\n"});
  endtask
  function automatic string hx(input logic [15:0] v);
    return $sformatf("%h", v);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("exp0", hx(capture_q[0].exposure), "0040");
    check("mode", hx(mode_q), "0000");
    $display("test reset done");
  endtask
  task automatic t_modes();
    cmd("!SETUP", "!SETUP=0\r\n");
    check("setup", hx({param_change_ok_q, job_change_ok_q}), "0002");
    cmd("!OFFLINE", "!OFFLINE=0\r\n");
    check("off", hx({param_change_ok_q, job_change_ok_q}), "0001");
    cmd("!TRIGGER", "!TRIGGER=0\r\n");
    check("offtrig", hx(16'(n_trig)), "0000");
    cmd("!RUN", "!RUN=0\r\n");
    check("run", hx({param_change_ok_q, job_change_ok_q}), "0001");
    $display("test modes done");
  endtask
  task automatic t_trigger();
    string r = "12345\r\n"; // Read result with its line end
    i_aci_host_model.slow = 1'b1;
    foreach (r[i])
      res_q.push_back(r[i]);
    cmd("!TRIGGER", "!TRIGGER=0\r\n12345\r\n", 2);
    check("trig", hx(16'(n_trig)), "0001");
    i_aci_host_model.slow = 1'b0;
    $display("test trigger done");
  endtask
  task automatic t_unknown();
    cmd("!run", "!run=100\r\n");
    cmd("!RUNX", "!RUNX=100\r\n");
    cmd("xy!SE!RUN", "!RUN=0\r\n");
    $display("test unknown done");
  endtask
  task automatic t_settings();
    scmd(nm_gain, ",1,40", "1");
    @(posedge clk_sys);
    job_loaded <= 1'b1;
    scmd(nm_gain, ",5,40", "2");
    scmd(nm_exp, ",0,9", "2");
    scmd(nm_gain, ",1,101", "3");
    check("gain1", hx(capture_q[0].gain), "0032");
    scmd(nm_exp, ",1,10001", "3");
    check("exp1", hx(capture_q[0].exposure), "0040");
    scmd(nm_exp, ",2", "101");
    scmd(nm_gain, ",2,40", "0");
    check("gain2", hx(capture_q[1].gain), "0028");
    scmd(nm_exp, ",4,10000", "0");
    check("exp4", hx(capture_q[3].exposure), "2710");
    $display("test settings done");
  endtask
  task automatic t_match();
    @(posedge clk_sys);
    match_text <= {4'h4, 32'h0, 32'h32343432};
    scmd(nm_mq, ",1", "0,2442");
    $display("test match done");
  endtask
  task automatic t_fieldbus();
    int k;
    @(posedge clk_sys);
    fieldbus_src <= 1'b1;
    i_aci_host_model.rx = "";
    i_aci_host_model.send({"!", nm_gain, ",9,1"});
    k = 0;
    while (fault_stb_q !== 1'b1 && k < 100)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 100)
    begin
      num_errors++;
      $display("mismatch fault strobe expected 1 seen 0");
      summarize();
    end
    check("fcode", hx(16'(fault_code_q)), "0002");
    repeat (4) @(posedge clk_sys);
    check("ftext", i_aci_host_model.rx, "");
    fieldbus_src <= 1'b0;
    $display("test fieldbus done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_modes();
    t_trigger();
    t_unknown();
    t_settings();
    t_match();
    t_fieldbus();
    summarize();
  end
endmodule // tb_top
